// File: logic/adcc_config_decode.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Bit 7 picks configuration or setup byte
// - Scan at 6:5, channel 4:1, type bit 0
// - Scan field chooses scan, resets to zero
// - Four-channel part forces upper channel bits zero
// - Type flag one single-ended, resets to one
// - Single-ended: input n positive, ground negative
// - Differential neighbours pair, odd code swaps polarity
// - Single-ended reference mode ignores shared pin, scan stops below
// - Reference mode pair reads ground against partner
// - Differential scan steps two up to limit
// - Setup reset bit zero restores configuration defaults
// - Reference mode excludes shared pin from scans
// - Power-on: single-ended, scan from zero up to input zero
// - Scan 01 repeats eight, 11 converts once
module adcc_config_decode
    import adcc_pkg::*;
#(
    parameter bit FOUR_CHAN = 1'b0
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Received write bytes
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    // Latched configuration
    output logic [1:0] scan_sel,
    output logic [3:0] chan_sel,
    output logic input_type_flag,
    output logic ref_pin_select,
    // Multiplexer selection
    output logic [3:0] pos_sel,
    output logic pos_is_gnd,
    output logic [3:0] neg_sel,
    output logic neg_is_gnd,
    output logic sel_ignored,
    // Scan plan
    output logic [3:0] scan_first,
    output logic [3:0] scan_last,
    output logic [1:0] scan_step,
    output logic [3:0] conv_count
);

    localparam logic [3:0] SHARED_PIN = FOUR_CHAN ? SHARED_PIN_FOUR : SHARED_PIN_TWELVE;
    localparam logic [3:0] MID_START = FOUR_CHAN ? MID_START_FOUR : MID_START_TWELVE;

    logic [1:0] scan_q, scan_d;
    logic [3:0] chan_q, chan_d;
    logic type_q, type_d;
    logic ref_q, ref_d;
    logic [3:0] pos_q, pos_d, neg_q, neg_d;
    logic pos_gnd_q, pos_gnd_d, neg_gnd_q, neg_gnd_d, ign_q, ign_d;
    logic [3:0] first_q, first_d, last_q, last_d, count_q, count_d;
    logic [1:0] step_q, step_d;
    logic [3:0] wr_chan;
    logic cfg_wr, setup_wr;

    adcc_sel_if sel_bus ();

    ////////////////////////////////////////////////////////////////////////////
    // Byte routing and register write

    assign cfg_wr = byte_valid && byte_data[BYTE_KIND_BIT] == KIND_CONFIG;
    assign setup_wr = byte_valid && byte_data[BYTE_KIND_BIT] == KIND_SETUP;

    // Next configuration and setup contents
    always_comb begin
        wr_chan = byte_data[CHAN_MSB_BIT:CHAN_LSB_BIT];
        if (FOUR_CHAN) begin
            wr_chan[3:2] = UPPER_ZERO;
        end
        scan_d = scan_q;
        chan_d = chan_q;
        type_d = type_q;
        ref_d = ref_q;
        if (cfg_wr) begin
            scan_d = {byte_data[SCAN_HI_BIT], byte_data[SCAN_LO_BIT]};
            chan_d = wr_chan;
            type_d = byte_data[TYPE_BIT];
        end else if (setup_wr) begin
            ref_d = byte_data[REF_SEL_BIT];
            if (byte_data[CFG_RESET_BIT] == CFG_RESET_ACTIVE) begin
                scan_d = SCAN_RESET;
                chan_d = CHAN_RESET;
                type_d = TYPE_RESET;
            end
        end
    end

    // Configuration registers, power-on defaults
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            scan_q <= SCAN_RESET;
            chan_q <= CHAN_RESET;
            type_q <= TYPE_RESET;
            ref_q <= REF_SEL_RESET;
        end else begin
            scan_q <= scan_d;
            chan_q <= chan_d;
            type_q <= type_d;
            ref_q <= ref_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Multiplexer mapping and scan plan

    assign sel_bus.chan = chan_q;
    assign sel_bus.single_ended = type_q;
    assign sel_bus.ref_sel = ref_q;
    assign sel_bus.four_chan = FOUR_CHAN;

    adcc_mux_map u_map (
        .sel(sel_bus)
    );

    // Scan bounds, step and repeat count from the latched configuration
    always_comb begin
        pos_d = sel_bus.pos;
        neg_d = sel_bus.neg;
        pos_gnd_d = sel_bus.pos_gnd;
        neg_gnd_d = sel_bus.neg_gnd;
        ign_d = sel_bus.ignored;
        step_d = type_q ? STEP_SINGLE : STEP_DIFF;
        first_d = chan_q;
        last_d = chan_q;
        count_d = COUNT_ONE;
        case (scan_q)
            SCAN_UP_FROM_ZERO: begin
                first_d = CHAN_ZERO;
                last_d = (chan_q > CHAN_TOP) ? CHAN_TOP : chan_q;
            end
            SCAN_UP_FROM_MID: begin
                first_d = MID_START;
                last_d = (chan_q > CHAN_TOP) ? CHAN_TOP : chan_q;
                if (last_d < MID_START) begin
                    last_d = MID_START;
                end
            end
            SCAN_REPEAT_EIGHT: begin
                count_d = COUNT_EIGHT;
            end
            default: begin
                count_d = COUNT_ONE;
            end
        endcase
        if (scan_q == SCAN_UP_FROM_ZERO || scan_q == SCAN_UP_FROM_MID) begin
            if (!type_q) begin
                last_d = {last_d[3:1], 1'b0};
            end else if (ref_q && last_d == SHARED_PIN) begin
                last_d = SHARED_PIN - CHAN_ONE;
            end
        end
    end

    // Registered selection outputs
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pos_q <= CHAN_RESET;
            neg_q <= CHAN_ZERO;
            pos_gnd_q <= 1'b0;
            neg_gnd_q <= 1'b1;
            ign_q <= 1'b0;
            first_q <= CHAN_ZERO;
            last_q <= CHAN_RESET;
            step_q <= STEP_SINGLE;
            count_q <= COUNT_ONE;
        end else begin
            pos_q <= pos_d;
            neg_q <= neg_d;
            pos_gnd_q <= pos_gnd_d;
            neg_gnd_q <= neg_gnd_d;
            ign_q <= ign_d;
            first_q <= first_d;
            last_q <= last_d;
            step_q <= step_d;
            count_q <= count_d;
        end
    end

    assign scan_sel = scan_q;
    assign chan_sel = chan_q;
    assign input_type_flag = type_q;
    assign ref_pin_select = ref_q;
    assign pos_sel = pos_q;
    assign neg_sel = neg_q;
    assign pos_is_gnd = pos_gnd_q;
    assign neg_is_gnd = neg_gnd_q;
    assign sel_ignored = ign_q;
    assign scan_first = first_q;
    assign scan_last = last_q;
    assign scan_step = step_q;
    assign conv_count = count_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    property p_setup_keeps_cfg;
        setup_wr && byte_data[CFG_RESET_BIT] != CFG_RESET_ACTIVE |=> $stable(chan_q) && $stable(scan_q);
    endproperty
    a_setup_keeps_cfg: assert property (p_setup_keeps_cfg) else $error("setup byte altered config");

    property p_cfg_layout;
        cfg_wr |=> scan_q == $past(byte_data[SCAN_HI_BIT:SCAN_LO_BIT])
            && type_q == $past(byte_data[TYPE_BIT]);
    endproperty
    a_cfg_layout: assert property (p_cfg_layout) else $error("config fields misplaced");

    property p_cfg_reset;
        setup_wr && byte_data[CFG_RESET_BIT] == CFG_RESET_ACTIVE
            |=> scan_q == SCAN_RESET && chan_q == CHAN_RESET && type_q == TYPE_RESET;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("config not restored");

    property p_four_upper;
        FOUR_CHAN |-> chan_q[3:2] == UPPER_ZERO;
    endproperty
    a_four_upper: assert property (p_four_upper) else $error("upper channel bits set");

    property p_single_map;
        type_q && !ref_q |=> neg_is_gnd && !pos_is_gnd && pos_sel == $past(chan_q);
    endproperty
    a_single_map: assert property (p_single_map) else $error("single-ended map wrong");

    property p_diff_map;
        !type_q && !ref_q |=> !neg_is_gnd && neg_sel == ($past(chan_q) ^ CHAN_ONE);
    endproperty
    a_diff_map: assert property (p_diff_map) else $error("differential map wrong");

    property p_ref_ignore;
        type_q && ref_q && chan_q == SHARED_PIN |=> sel_ignored;
    endproperty
    a_ref_ignore: assert property (p_ref_ignore) else $error("shared pin not ignored");

    property p_ref_diff;
        !type_q && ref_q && chan_q == SHARED_PIN |=> pos_is_gnd && neg_sel == SHARED_PIN - CHAN_ONE;
    endproperty
    a_ref_diff: assert property (p_ref_diff) else $error("reference pair map wrong");

    property p_diff_step;
        !type_q && (scan_q == SCAN_UP_FROM_ZERO || scan_q == SCAN_UP_FROM_MID)
            |=> scan_step == STEP_DIFF && scan_last[0] == 1'b0;
    endproperty
    a_diff_step: assert property (p_diff_step) else $error("differential step wrong");

    property p_scan_exclude;
        type_q && ref_q && scan_q == SCAN_UP_FROM_ZERO |=> scan_last != SHARED_PIN;
    endproperty
    a_scan_exclude: assert property (p_scan_exclude) else $error("shared pin in scan");

    property p_repeat_count;
        scan_q == SCAN_REPEAT_EIGHT |=> conv_count == COUNT_EIGHT;
    endproperty
    a_repeat_count: assert property (p_repeat_count) else $error("repeat count wrong");

    c_cfg_write: cover property (cfg_wr ##1 !type_q);
    c_ref_ignore: cover property (ref_q && sel_ignored);
    c_reset_byte: cover property (setup_wr && byte_data[CFG_RESET_BIT] == CFG_RESET_ACTIVE);

endmodule // adcc_config_decode

// File: logic/adcc_mux_map.sv
`timescale 1ns/1ps
module adcc_mux_map
    import adcc_pkg::*;
(
    // Selection in and multiplexer choice out
    adcc_sel_if.map sel
);

    logic [3:0] shared_pin;

    // Maps the channel code onto positive and negative multiplexer inputs
    always_comb begin
        shared_pin = sel.four_chan ? SHARED_PIN_FOUR : SHARED_PIN_TWELVE;
        sel.pos = sel.chan;
        sel.pos_gnd = 1'b0;
        sel.neg = CHAN_ZERO;
        sel.neg_gnd = 1'b0;
        sel.ignored = 1'b0;
        if (sel.single_ended) begin
            sel.neg_gnd = 1'b1;
            if (sel.ref_sel && sel.chan == shared_pin) begin
                sel.ignored = 1'b1;
            end
        end else begin
            // Even code pairs upward, odd code downward with swapped polarity
            sel.neg = sel.chan ^ CHAN_ONE;
            if (sel.ref_sel && (sel.chan | CHAN_ONE) == shared_pin) begin
                if (sel.chan == shared_pin) begin
                    sel.pos = CHAN_ZERO;
                    sel.pos_gnd = 1'b1;
                end else begin
                    sel.neg = CHAN_ZERO;
                    sel.neg_gnd = 1'b1;
                end
            end
        end
    end

endmodule // adcc_mux_map

// File: logic/adcc_pkg.sv
package adcc_pkg;

    // Bit positions in a received write byte
    localparam int BYTE_KIND_BIT = 7;
    localparam int SCAN_HI_BIT = 6;
    localparam int SCAN_LO_BIT = 5;
    localparam int CHAN_MSB_BIT = 4;
    localparam int CHAN_LSB_BIT = 1;
    localparam int TYPE_BIT = 0;
    localparam int REF_SEL_BIT = 5;
    localparam int CFG_RESET_BIT = 1;

    // Byte kind and reset bit levels
    localparam logic KIND_CONFIG = 1'b0;
    localparam logic KIND_SETUP = 1'b1;
    localparam logic CFG_RESET_ACTIVE = 1'b0;

    // Reset contents
    localparam logic [1:0] SCAN_RESET = 2'h0;
    localparam logic [3:0] CHAN_RESET = 4'h0;
    localparam logic TYPE_RESET = 1'b1;
    localparam logic REF_SEL_RESET = 1'b0;

    // Scan field encodings
    localparam logic [1:0] SCAN_UP_FROM_ZERO = 2'h0;
    localparam logic [1:0] SCAN_REPEAT_EIGHT = 2'h1;
    localparam logic [1:0] SCAN_UP_FROM_MID = 2'h2;
    localparam logic [1:0] SCAN_SINGLE = 2'h3;

    // Channel indices and counts
    localparam logic [3:0] CHAN_TOP = 4'hb;
    localparam logic [3:0] SHARED_PIN_FOUR = 4'h3;
    localparam logic [3:0] SHARED_PIN_TWELVE = 4'hb;
    localparam logic [3:0] MID_START_FOUR = 4'h2;
    localparam logic [3:0] MID_START_TWELVE = 4'h6;
    localparam logic [3:0] CHAN_ONE = 4'h1;
    localparam logic [3:0] CHAN_ZERO = 4'h0;
    localparam logic [3:0] COUNT_EIGHT = 4'h8;
    localparam logic [3:0] COUNT_ONE = 4'h1;
    localparam logic [1:0] STEP_SINGLE = 2'h1;
    localparam logic [1:0] STEP_DIFF = 2'h2;
    localparam logic [1:0] UPPER_ZERO = 2'h0;

endpackage

// File: logic/adcc_sel_if.sv
`timescale 1ns/1ps
interface adcc_sel_if;
    logic [3:0] chan;
    logic single_ended;
    logic ref_sel;
    logic four_chan;
    logic [3:0] pos;
    logic pos_gnd;
    logic [3:0] neg;
    logic neg_gnd;
    logic ignored;

    modport ctrl (output chan, single_ended, ref_sel, four_chan,
                  input pos, pos_gnd, neg, neg_gnd, ignored);
    modport map (input chan, single_ended, ref_sel, four_chan,
                 output pos, pos_gnd, neg, neg_gnd, ignored);
endinterface // adcc_sel_if

// File: testbench/adcc_byte_master.sv
`timescale 1ns/1ps
module adcc_byte_master (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Byte stream toward the decoder
    output logic byte_valid,
    output logic [7:0] byte_data
);
    logic [7:0] last_byte;

    // Idle bus at time zero
    initial begin
        byte_valid = 1'b0;
        byte_data = 8'h00;
        last_byte = 8'h00;
    end

    // One received write byte as a one-cycle pulse
    task automatic send(input logic [7:0] value);
        if (value[7] == 1'b0 && value[4:1] > 4'hb) begin
            return;
        end
        wait (reset_n === 1'b1);
        @(posedge clock);
        #1;
        byte_valid = 1'b1;
        byte_data = value;
        last_byte = value;
        @(posedge clock);
        #1;
        byte_valid = 1'b0;
        byte_data = ~last_byte; // Stale byte never lingers
    endtask
endmodule // adcc_byte_master

// File: testbench/test_adc_channel_config_decode.sv
`timescale 1ns/1ps
module test_adc_channel_config_decode
    import adcc_pkg::*;
;
    logic clock, reset_n, byte_valid;
    logic [7:0] byte_data;
    logic [1:0] scan_sel, step;
    logic [3:0] chan_sel, pos_sel, neg_sel, first, last, count, chan4, pos4, first4, last4;
    logic type_flag, ref_sel, pos_gnd, neg_gnd, ign, ign4;
    int fail_count = 0;
    int num_checks = 0;

    ////////////////////////////////////////////////////////////////
    adcc_byte_master host (.clock(clock), .reset_n(reset_n), .byte_valid(byte_valid),
        .byte_data(byte_data));
    adcc_config_decode #(.FOUR_CHAN(1'b0)) dut (.clock(clock), .reset_n(reset_n),
        .byte_valid(byte_valid), .byte_data(byte_data), .scan_sel(scan_sel),
        .chan_sel(chan_sel), .input_type_flag(type_flag), .ref_pin_select(ref_sel),
        .pos_sel(pos_sel), .pos_is_gnd(pos_gnd), .neg_sel(neg_sel), .neg_is_gnd(neg_gnd),
        .sel_ignored(ign), .scan_first(first), .scan_last(last), .scan_step(step),
        .conv_count(count));
    adcc_config_decode #(.FOUR_CHAN(1'b1)) dut_four (.clock(clock), .reset_n(reset_n),
        .byte_valid(byte_valid), .byte_data(byte_data), .scan_sel(), .chan_sel(chan4),
        .input_type_flag(), .ref_pin_select(), .pos_sel(pos4), .pos_is_gnd(),
        .neg_sel(), .neg_is_gnd(), .sel_ignored(ign4), .scan_first(first4),
        .scan_last(last4), .scan_step(), .conv_count());

    ////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Send a byte and wait until derived outputs settle
    task automatic put(input logic [7:0] value);
        host.send(value);
        @(posedge clock);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Clock generator
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Watchdog well beyond the expected run length
    initial begin
        #5000;
        fail_count++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        reset_n = 1'b0;
        repeat (20) @(posedge clock);
        #1;
        reset_n = 1'b1;
        check({2'h0, scan_sel}, 4'h0);
        check(chan_sel, 4'h0);
        check({3'h0, type_flag}, 4'h1);
        check({3'h0, ref_sel}, 4'h0);
        check({3'h0, pos_gnd}, 4'h0);
        check({3'h0, neg_gnd}, 4'h1);
        check(count, 4'h1);
        // Every legal code in both input types
        for (int n = 0; n < 12; n++) begin
            for (int t = 0; t < 2; t++) begin
                put({1'b0, 2'h3, 4'(n), 1'(t)});
                check(chan_sel, 4'(n));
                check({3'h0, type_flag}, {3'h0, 1'(t)});
                check(pos_sel, 4'(n));
                check({3'h0, pos_gnd}, 4'h0);
                check({3'h0, neg_gnd}, {3'h0, 1'(t)});
                check({3'h0, ign}, 4'h0);
                check(chan4, {2'h0, 2'(n)});
                check(pos4, {2'h0, 2'(n)});
                if (t == 0) begin
                    check(neg_sel, 4'(n) ^ 4'h1);
                end
            end
        end
        // All scan field values
        for (int s = 0; s < 4; s++) begin
            put({1'b0, 2'(s), 4'h8, 1'b1});
            check({2'h0, scan_sel}, {2'h0, 2'(s)});
            check(count, (s == 1) ? 4'h8 : 4'h1);
            if (s == 0) begin
                check(first, 4'h0);
                check(last, 4'h8);
                check({2'h0, step}, 4'h1);
            end
            if (s == 2) begin
                check(first, 4'h6);
                check(last, 4'h8);
                check(first4, 4'h2);
                check(last4, 4'h2);
            end
            if (s == 3) begin
                check(first, 4'h8);
                check(last, 4'h8);
            end
        end
        // Differential scans step by two
        put(8'h16);
        check(last, 4'ha);
        check({2'h0, step}, 4'h2);
        put(8'h12);
        check(last, 4'h8);
        // Setup byte without reset leaves configuration alone, with reset bit zero restores it
        put(8'h82);
        check(chan_sel, 4'h9);
        check({3'h0, type_flag}, 4'h0);
        put(8'h80);
        check(chan_sel, 4'h0);
        check({3'h0, type_flag}, 4'h1);
        // Shared pin as reference
        put(8'ha2);
        check({3'h0, ref_sel}, 4'h1);
        check(chan_sel, 4'h0);
        put(8'h77);
        check({3'h0, ign}, 4'h1);
        check({3'h0, ign4}, 4'h1);
        put(8'h17);
        check(last, 4'ha);
        check(last4, 4'h2);
        put(8'h16);
        check({3'h0, pos_gnd}, 4'h1);
        check(neg_sel, 4'ha);
        put(8'h14);
        check(pos_sel, 4'ha);
        check({3'h0, neg_gnd}, 4'h1);
        // Reset bit restores defaults
        put(8'h6c);
        check({2'h0, scan_sel}, 4'h3);
        check(chan_sel, 4'h6);
        put(8'ha0);
        check(chan_sel, 4'h0);
        check({2'h0, scan_sel}, 4'h0);
        check({3'h0, type_flag}, 4'h1);
        check({3'h0, ref_sel}, 4'h1);
        // Reset in mid-run returns the power-on state
        put(8'h6c);
        check({3'h0, neg_gnd}, 4'h0);
        reset_n = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        reset_n = 1'b1;
        check({2'h0, scan_sel}, 4'h0);
        check(chan_sel, 4'h0);
        check({3'h0, type_flag}, 4'h1);
        check({3'h0, ref_sel}, 4'h0);
        check({3'h0, neg_gnd}, 4'h1);
        tally_and_finish();
    end
endmodule // test_adc_channel_config_decode
